// ===== include/tmr_pkg.sv
// Overview of operation
// [RULE_01] timer and pulse modes count clock divided by 4
// [RULE_02] event mode counts transitions on the input pin
// [RULE_03] count to ffff, overflow, reload preload, continue
// [RULE_04] stopped: preload write also loads the count
// [RULE_05] running: new preload waits for next overflow
// [RULE_06] low write buffered; high write moves buffer in
// [RULE_07] software writes low byte before high byte
// [RULE_08] high read latches low byte into buffer
// [RULE_09] control bit 4 runs or stops the counter
// [RULE_10] control bit 3 picks the active input edge
// [RULE_11] mode 10 is timer mode, one count per tick
// [RULE_12] mode 01 is event mode, one count per edge
// [RULE_13] edge select zero rising, one falling, in event mode
// [RULE_14] event mode keeps counting during power down
// [RULE_15] mode 11 is pulse width mode on divided clock
// [RULE_16] edge zero: start on fall, stop on rise
// [RULE_17] edge one: start on rise, stop on fall
// [RULE_18] timer and event modes never clear run themselves
// [RULE_19] after auto stop, edges ignored until run set
// [RULE_20] pulse measurement uses edges, not static levels
// [RULE_21] overflow interrupt only while its enable is set
// [RULE_22] host sets the shared pin as an input
// [RULE_23] preload holds no defined value after power on
// [RULE_24] every overflow sets the timer request flag
// [RULE_25] counting paused during count reads or preload writes
// [RULE_26] input pin synchronised, edges detected on system clock
package tmr_pkg;
	// data and counter widths
	localparam int DATA_W = 8;
	localparam int COUNT_W = 16;
	// register select width and register indices
	localparam int SEL_W = 2;
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_HIGH = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	// control register field positions
	localparam int MODE_HI_BIT = 7;
	localparam int MODE_LO_BIT = 6;
	localparam int RUN_BIT = 4;
	localparam int EDGE_BIT = 3;
	// implemented control bits and reset value
	localparam logic [7:0] CTRL_MASK = 8'hd8;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// mode encodings, {high select, low select}
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_EVENT = 2'h1;
	localparam logic [1:0] MODE_TIMER = 2'h2;
	localparam logic [1:0] MODE_PULSE = 2'h3;
	// reset values and full count
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_FULL = 16'hffff;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// system clock cycles per timer clock tick
	localparam int TICK_DIV = 4;
	// pulse width measurement progress
	typedef enum logic {PW_WAIT, PW_COUNT} pw_state_t;
endpackage

// ===== include/tmr_pin_if.sv
`timescale 1ns/10ps
// carries the divided tick and pin edges to the counter
interface tmr_pin_if;
	logic div_tick; // one-cycle timer clock tick
	logic pin_rise; // one-cycle rising edge seen
	logic pin_fall; // one-cycle falling edge seen
	modport src (output div_tick, output pin_rise, output pin_fall);
	modport snk (input div_tick, input pin_rise, input pin_fall);
endinterface

// ===== rtl/tmr_pin_front.sv
`timescale 1ns/10ps
// divider and input pin edge detector
module tmr_pin_front #(
	parameter int DIV = tmr_pkg::TICK_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and power state
	input wire logic pin,
	input wire logic power_down,
	// towards the counter
	tmr_pin_if.src ev
);
	import tmr_pkg::*;

	// refuse divider values the 8-bit phase counter cannot serve
	if (DIV < 2 || DIV > 256) begin
		$error("tmr_pin_front: DIV must be 2..256");
	end

	localparam logic [7:0] DIV_LAST = 8'(DIV - 1);

	logic sync1_reg; // first synchroniser stage
	logic sync2_reg; // second synchroniser stage
	logic prev_reg; // previous synchronised level
	logic [7:0] div_reg; // divider phase

	////////////////////////////////////////////////////////////////
	// two-flop synchroniser and edge memory
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			sync1_reg <= pin; // RULE_26
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// edges only, the level itself never counts
	assign ev.pin_rise = sync2_reg && !prev_reg; // RULE_26
	assign ev.pin_fall = !sync2_reg && prev_reg; // RULE_26

	////////////////////////////////////////////////////////////////
	// divide by DIV; the divider phase holds in power down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
		end else if (!power_down) begin
			div_reg <= (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
		end
	end

	assign ev.div_tick = !power_down && (div_reg == DIV_LAST); // RULE_01
endmodule

// ===== rtl/tmr_event_counter.sv
`timescale 1ns/10ps
// 16-bit up counter: interval timer, event counter, pulse width
module tmr_event_counter (
	// clock and reset
	input wire logic MCLK,
	input wire logic NRST,
	// register access
	input wire logic [tmr_pkg::SEL_W-1:0] REG_SEL,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [tmr_pkg::DATA_W-1:0] REG_WDATA,
	output logic [tmr_pkg::DATA_W-1:0] REG_RDATA,
	// external pin and device state
	input wire logic TIMER_INPUT_PIN,
	input wire logic POWER_DOWN,
	input wire logic OVERFLOW_IRQ_ENABLE,
	// overflow signalling
	output logic TIMER_REQUEST,
	output logic TIMER_IRQ
);
	import tmr_pkg::*;

	////////////////////////////////////////////////////////////////
	// declarations
	tmr_pin_if ev(); // tick and pin edges
	logic [7:0] ctrl_reg; // control register
	logic [15:0] count_reg; // live count
	logic [15:0] count_next; // count after this cycle
	logic [7:0] preload_hi_reg; // preload high byte
	logic [7:0] preload_lo_reg; // preload low byte
	logic [7:0] low_buf_reg; // shared low byte holding buffer
	pw_state_t pw_reg; // pulse measurement progress
	logic [1:0] mode; // current mode field
	logic run; // counter run bit
	logic edge_sel; // active edge select
	logic wr_low; // write to low count byte
	logic wr_high; // write to high count byte
	logic wr_ctrl; // write to control
	logic rd_high; // read of high count byte
	logic inhibit; // count clock held off by access
	logic tick; // mode-selected count clock
	logic inc; // count advances this cycle
	logic ovf; // count wraps this cycle
	logic start_edge; // pulse start edge
	logic end_edge; // pulse end edge
	logic pw_stop; // pulse ended, run auto-clears

	// pick rising edge for select zero, falling for one
	function automatic logic pick_edge(input logic pol, input logic rise,
			input logic fall);
		pick_edge = pol ? fall : rise;
	endfunction

	////////////////////////////////////////////////////////////////
	// pin synchroniser and divider
	tmr_pin_front #(
		.DIV(TICK_DIV)
	) u_front (
		.clk(MCLK),
		.rst_n(NRST),
		.pin(TIMER_INPUT_PIN),
		.power_down(POWER_DOWN),
		.ev(ev.src)
	);

	////////////////////////////////////////////////////////////////
	// access decode
	assign wr_low = REG_WR && (REG_SEL == SEL_LOW);
	assign wr_high = REG_WR && (REG_SEL == SEL_HIGH);
	assign wr_ctrl = REG_WR && (REG_SEL == SEL_CTRL);
	assign rd_high = REG_RD && (REG_SEL == SEL_HIGH);
	// count reads and preload writes hold the count clock
	assign inhibit = wr_low || wr_high ||
		(REG_RD && (REG_SEL == SEL_LOW || REG_SEL == SEL_HIGH)); // RULE_25

	assign mode = {ctrl_reg[MODE_HI_BIT], ctrl_reg[MODE_LO_BIT]};
	assign run = ctrl_reg[RUN_BIT];
	assign edge_sel = ctrl_reg[EDGE_BIT];

	////////////////////////////////////////////////////////////////
	// edge choice: start on the leading edge, end on the trailing one
	assign start_edge = pick_edge(!edge_sel, ev.pin_rise, ev.pin_fall); // RULE_10
	assign end_edge = pick_edge(edge_sel, ev.pin_rise, ev.pin_fall); // RULE_10

	// count clock source per mode
	always_comb begin
		case (mode)
			MODE_TIMER: tick = ev.div_tick; // RULE_01 RULE_11
			// pin edges, independent of power down
			MODE_EVENT: tick = pick_edge(edge_sel, ev.pin_rise,
				ev.pin_fall); // RULE_02 RULE_12 RULE_13 RULE_14
			// divided clock only between the pulse edges
			MODE_PULSE: tick = ev.div_tick && (pw_reg == PW_COUNT); // RULE_15
			default: tick = 1'b0; // unused mode never counts
		endcase
	end

	assign inc = run && !inhibit && tick; // RULE_09 RULE_25
	assign ovf = inc && (count_reg == COUNT_FULL); // RULE_03
	assign pw_stop = run && (mode == MODE_PULSE) && (pw_reg == PW_COUNT) &&
		end_edge; // RULE_16 RULE_17 RULE_20

	////////////////////////////////////////////////////////////////
	// next count value
	always_comb begin
		count_next = count_reg;
		if (wr_high && !run) begin
			count_next = {REG_WDATA, low_buf_reg}; // RULE_04
		end else if (ovf) begin
			count_next = {preload_hi_reg, preload_lo_reg}; // RULE_03 RULE_05
		end else if (inc) begin
			count_next = count_reg + 16'h0001; // RULE_03
		end
	end

	// live count register
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			count_reg <= COUNT_RESET;
		end else begin
			count_reg <= count_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// preload pair, left unset by reset
	always_ff @(posedge MCLK) begin
		if (wr_high) begin
			preload_hi_reg <= REG_WDATA; // RULE_06 RULE_23
			preload_lo_reg <= low_buf_reg; // RULE_06
		end
	end

	// low byte holding buffer, shared by writes and reads
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			low_buf_reg <= BYTE_RESET;
		end else if (wr_low) begin
			low_buf_reg <= REG_WDATA; // RULE_06
		end else if (rd_high) begin
			low_buf_reg <= count_reg[7:0]; // RULE_08
		end
	end

	////////////////////////////////////////////////////////////////
	// control register; a software write beats the auto-clear
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= REG_WDATA & CTRL_MASK; // RULE_09
		end else if (pw_stop) begin
			ctrl_reg[RUN_BIT] <= 1'b0; // RULE_16 RULE_17 RULE_18
		end
	end

	// pulse measurement: wait for leading edge, count to trailing
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pw_reg <= PW_WAIT;
		end else if (!run || mode != MODE_PULSE || wr_ctrl) begin
			pw_reg <= PW_WAIT; // RULE_19
		end else begin
			case (pw_reg)
				PW_WAIT: begin
					if (start_edge) begin
						pw_reg <= PW_COUNT; // RULE_16 RULE_17 RULE_20
					end
				end
				PW_COUNT: begin
					if (end_edge) begin
						pw_reg <= PW_WAIT;
					end
				end
				default: pw_reg <= PW_WAIT;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// overflow request and gated interrupt
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			TIMER_REQUEST <= 1'b0;
			TIMER_IRQ <= 1'b0;
		end else begin
			TIMER_REQUEST <= ovf; // RULE_24
			TIMER_IRQ <= ovf && OVERFLOW_IRQ_ENABLE; // RULE_21
		end
	end

	// read data, low byte comes from the buffer
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= BYTE_RESET;
		end else if (REG_RD) begin
			case (REG_SEL)
				SEL_LOW: REG_RDATA <= low_buf_reg; // RULE_08
				SEL_HIGH: REG_RDATA <= count_reg[15:8];
				SEL_CTRL: REG_RDATA <= ctrl_reg;
				default: REG_RDATA <= BYTE_RESET; // unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	sequence seq_hi_read;
		rd_high && !wr_low;
	endsequence

	sequence seq_lo_read;
		REG_RD && (REG_SEL == SEL_LOW) && !REG_WR;
	endsequence

	sequence seq_pulse_end;
		run && mode == MODE_PULSE && pw_reg == PW_COUNT && end_edge &&
			!wr_ctrl;
	endsequence

	AST_TIMER_TICK: assert property ( // RULE_11
		run && mode == MODE_TIMER && ev.div_tick && !inhibit &&
		count_reg != COUNT_FULL |=> count_reg == $past(count_reg) + 16'h0001)
		else $error("timer tick did not advance count");

	AST_TIMER_QUIET: assert property ( // RULE_01
		mode == MODE_TIMER && !ev.div_tick && !wr_high
		|=> count_reg == $past(count_reg))
		else $error("timer counted without divided tick");

	AST_EVENT_EDGE: assert property ( // RULE_13
		run && mode == MODE_EVENT && !inhibit && count_reg != COUNT_FULL &&
		(edge_sel ? ev.pin_fall : ev.pin_rise)
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("event edge not counted");

	AST_OVF_RELOAD: assert property ( // RULE_03
		ovf |=> TIMER_REQUEST &&
		count_reg == {$past(preload_hi_reg), $past(preload_lo_reg)})
		else $error("overflow did not reload and request");

	AST_STOPPED_LOAD: assert property ( // RULE_04
		wr_high && !run |=> count_reg == {$past(REG_WDATA), $past(low_buf_reg)})
		else $error("stopped preload write missed count");

	AST_RUNNING_HOLD: assert property ( // RULE_05
		wr_high && run |=> count_reg == $past(count_reg) &&
		preload_hi_reg == $past(REG_WDATA))
		else $error("running preload write touched count");

	AST_LATCH_READ: assert property ( // RULE_08
		seq_hi_read ##1 seq_lo_read |=> REG_RDATA == $past(count_reg[7:0], 2))
		else $error("low read did not return latched byte");

	AST_IRQ_GATE: assert property ( // RULE_21
		TIMER_IRQ |-> TIMER_REQUEST && $past(OVERFLOW_IRQ_ENABLE))
		else $error("interrupt without enable");

	AST_PULSE_STOP: assert property ( // RULE_16
		seq_pulse_end |=> !run ##1 (!run || $past(wr_ctrl)))
		else $error("pulse end did not clear run");

	AST_NO_SELF_CLEAR: assert property ( // RULE_18
		run && mode != MODE_PULSE && !wr_ctrl |=> run)
		else $error("run cleared without software");

	AST_PULSE_WAIT: assert property ( // RULE_20
		pw_reg == PW_WAIT && mode == MODE_PULSE && !wr_high
		|=> count_reg == $past(count_reg))
		else $error("pulse counted before leading edge");

	// count byte reads and low writes freeze the count for that cycle
	AST_INHIBIT_HOLD: assert property ( // RULE_25
		inhibit && !wr_high |=> count_reg == $past(count_reg))
		else $error("count moved during register access");

	// a lone low write lands in the buffer only
	AST_LOW_BUFFER: assert property ( // RULE_06
		wr_low |=> low_buf_reg == $past(REG_WDATA) &&
		count_reg == $past(count_reg))
		else $error("low write did not stay in buffer");

	// request pulse only ever follows an overflow
	AST_REQ_ONLY_OVF: assert property ( // RULE_24
		TIMER_REQUEST |-> $past(ovf))
		else $error("request without overflow");

	// enabled overflow must raise the interrupt
	AST_IRQ_ON: assert property ( // RULE_21
		ovf && OVERFLOW_IRQ_ENABLE |=> TIMER_IRQ)
		else $error("enabled overflow gave no interrupt");

	// masked overflow must stay silent
	AST_IRQ_OFF: assert property ( // RULE_21
		ovf && !OVERFLOW_IRQ_ENABLE |=> !TIMER_IRQ)
		else $error("masked overflow gave an interrupt");

	// leading edge seen while armed and waiting
	sequence seq_pulse_arm;
		run && mode == MODE_PULSE && pw_reg == PW_WAIT && start_edge &&
			!wr_ctrl;
	endsequence

	AST_PULSE_ARM: assert property ( // RULE_17
		seq_pulse_arm |=> pw_reg == PW_COUNT)
		else $error("leading edge did not arm counting");

	// once stopped, only software may start it again
	AST_STOP_IGNORE: assert property ( // RULE_19
		!run && !wr_ctrl |=> !run && pw_reg == PW_WAIT)
		else $error("stopped counter restarted by itself");

	// divided tick halts in power down, so timer mode holds
	AST_POWER_HALT: assert property ( // RULE_01
		POWER_DOWN && mode == MODE_TIMER && !wr_high
		|=> count_reg == $past(count_reg))
		else $error("timer counted in power down");
endmodule

// ===== test/tmr_pin_model.sv
`timescale 1ns/10ps
// external source on the timer input pin: levels and single pulses
module tmr_pin_model (
	// bench clock, used to time pin changes
	input wire logic clk,
	// pin level seen by the counter
	output logic pin
);
	// idle high until a scenario moves it
	initial begin
		pin = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// move the pin just after a falling clock edge
	task automatic level(input logic lvl);
		@(negedge clk);
		pin = lvl;
	endtask
	// one pulse away from idle and back, held cyc cycles
	task automatic pulse(input logic idle, input int cyc);
		level(~idle);
		repeat (cyc) @(negedge clk);
		pin = idle;
	endtask
endmodule

// ===== test/tmr_event_counter_tb.sv
`timescale 1ns/10ps
// self-checking bench for the 16-bit timer and event counter
module tmr_event_counter_tb;
	import tmr_pkg::*;
	// design stimulus and response
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [SEL_W-1:0] sel = SEL_CTRL;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] wdata = BYTE_RESET;
	logic [DATA_W-1:0] rdata;
	logic pin;
	logic pdown = 1'b0;
	logic irq_en = 1'b0;
	logic treq;
	logic tirq;
	// counters and scratch values
	int n_fail = 0;
	int num_checks = 0;
	logic [7:0] b;
	logic [15:0] cnt;
	logic [15:0] first;
	// table row: select, byte written, byte read back
	typedef struct {logic [1:0] s; logic [7:0] w; logic [7:0] r;} row_t;
	row_t rows [6] = '{'{SEL_CTRL, 8'hff, 8'hd8}, '{SEL_CTRL, 8'h27, 8'h00},
		'{SEL_CTRL, 8'h08, 8'h08}, '{2'h3, 8'hff, 8'h00},
		'{SEL_HIGH, 8'h5a, 8'h5a}, '{SEL_CTRL, 8'h00, 8'h00}};
	// clock of 20 ns period
	always #10 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	tmr_event_counter DUT (
		.MCLK(mclk), .NRST(nrst), .REG_SEL(sel), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .TIMER_INPUT_PIN(pin),
		.POWER_DOWN(pdown), .OVERFLOW_IRQ_ENABLE(irq_en),
		.TIMER_REQUEST(treq), .TIMER_IRQ(tirq)
	);
	// far-side pulse source
	tmr_pin_model partner (.clk(mclk), .pin(pin));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s %h/%h", $time, msg, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// one-cycle register write
	task automatic wr_reg(input logic [1:0] s, input logic [7:0] d);
		@(negedge mclk);
		sel = s;
		wdata = d;
		wr = 1'b1;
		@(negedge mclk);
		wr = 1'b0;
	endtask
	// one-cycle register read, data taken a cycle later
	task automatic rd_reg(input logic [1:0] s, output logic [7:0] d);
		@(negedge mclk);
		sel = s;
		rd = 1'b1;
		@(negedge mclk);
		rd = 1'b0;
		d = rdata;
	endtask
	// 16-bit load, low byte first
	task automatic wr16(input logic [15:0] v);
		wr_reg(SEL_LOW, v[7:0]);
		wr_reg(SEL_HIGH, v[15:8]);
	endtask
	// 16-bit read, high byte latches the low byte
	task automatic rd16(output logic [15:0] v);
		rd_reg(SEL_HIGH, v[15:8]);
		rd_reg(SEL_LOW, v[7:0]);
	endtask
	// bounded wait for an overflow pulse
	task automatic wait_req;
		int k;
		for (k = 0; k < 300; k++) begin
			@(negedge mclk);
			if (treq === 1'b1) break;
		end
		if (k == 300) begin
			check(1'b0, 1'b1, "no overflow");
			final_report;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(negedge mclk);
		check({treq, tirq, rdata}, 16'h0000, "reset outputs");
		nrst = 1'b1;
		rd_reg(SEL_CTRL, b);
		check(b, CTRL_RESET, "ctrl reset");
		// table of register writes and read-backs
		foreach (rows[n]) begin
			wr_reg(rows[n].s, rows[n].w);
			rd_reg(rows[n].s, b);
			check(b, rows[n].r, "table");
		end
		// stopped load, then a lone low write stays buffered
		wr16(16'h1234);
		rd16(cnt);
		check(cnt, 16'h1234, "stopped load");
		wr_reg(SEL_LOW, 8'h77);
		rd16(cnt);
		check(cnt, 16'h1234, "low buffer");
		// timer rate, one count per four clocks
		wr16(16'h0000);
		wr_reg(SEL_CTRL, 8'h90);
		repeat (40) @(negedge mclk);
		wr_reg(SEL_CTRL, 8'h80);
		rd16(cnt);
		check(cnt >= 9 && cnt <= 11, 1'b1, "tick rate");
		// overflow with interrupt off, preload change while running
		wr16(16'hfff0);
		wr_reg(SEL_CTRL, 8'h90);
		wait_req;
		check(tirq, 1'b0, "irq masked");
		wr16(16'h8000);
		rd_reg(SEL_HIGH, b);
		check(b, 8'hff, "preload held");
		irq_en = 1'b1;
		wait_req;
		check(tirq, 1'b1, "irq on");
		rd_reg(SEL_HIGH, b);
		check(b, 8'h80, "reload");
		wr_reg(SEL_CTRL, 8'h80);
		// event counting in power down, rising then falling edges
		pdown = 1'b1;
		wr16(16'h0000);
		partner.level(1'b0);
		wr_reg(SEL_CTRL, 8'h50);
		partner.level(1'b1);
		repeat (4) @(negedge mclk);
		partner.level(1'b0);
		repeat (3) partner.pulse(1'b0, 3);
		repeat (5) @(negedge mclk);
		wr_reg(SEL_CTRL, 8'h40);
		rd16(cnt);
		check(cnt, 16'h0004, "rising");
		wr16(16'h0000);
		wr_reg(SEL_CTRL, 8'h58);
		partner.level(1'b1);
		repeat (3) partner.pulse(1'b1, 3);
		repeat (5) @(negedge mclk);
		rd_reg(SEL_CTRL, b);
		check(b, 8'h58, "run kept");
		wr_reg(SEL_CTRL, 8'h48);
		rd16(cnt);
		check(cnt, 16'h0003, "falling");
		pdown = 1'b0;
		// low pulse width, then a second pulse is ignored
		wr16(16'h0000);
		wr_reg(SEL_CTRL, 8'hd0);
		repeat (20) @(negedge mclk);
		partner.pulse(1'b1, 40);
		repeat (6) @(negedge mclk);
		rd_reg(SEL_CTRL, b);
		check(b, 8'hc0, "auto stop");
		rd16(first);
		check(first >= 9 && first <= 11, 1'b1, "width");
		partner.pulse(1'b1, 40);
		repeat (6) @(negedge mclk);
		rd16(cnt);
		check(cnt, first, "ignored");
		// high pulse; a standing high level alone starts nothing
		wr16(16'h0000);
		wr_reg(SEL_CTRL, 8'hd8);
		repeat (30) @(negedge mclk);
		rd16(cnt);
		check(cnt, 16'h0000, "static");
		partner.level(1'b0);
		partner.pulse(1'b0, 20);
		repeat (6) @(negedge mclk);
		rd_reg(SEL_CTRL, b);
		check(b, 8'hc8, "auto stop hi");
		rd16(cnt);
		check(cnt >= 4 && cnt <= 6, 1'b1, "width hi");
		// reset in mid-run while the timer counts
		wr16(16'h1000);
		wr_reg(SEL_CTRL, 8'h90);
		repeat (10) @(negedge mclk);
		nrst = 1'b0;
		@(negedge mclk);
		check(rdata, BYTE_RESET, "reset rdata");
		check({treq, tirq}, 16'h0000, "reset req");
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		rd_reg(SEL_CTRL, b);
		check(b, CTRL_RESET, "ctrl after reset");
		rd16(cnt);
		check(cnt, COUNT_RESET, "count after reset");
		final_report;
	end
endmodule
